// ===== dma_unit_cfg.svh
`ifndef DMA_UNIT_CFG_SVH
`define DMA_UNIT_CFG_SVH

// ----------------------------------------
// command word layout
// ----------------------------------------
`define CMD_OPC_HI 15
`define CMD_OPC_LO 12
`define CMD_PAR_HI 11
`define CMD_PAR_LO 0
`define PTR_HI 9

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OPC_LD_IN_BASE 4'h0
`define OPC_LD_IN_LIMIT 4'h1
`define OPC_LD_OUT_BASE 4'h2
`define OPC_LD_OUT_LIMIT 4'h3
`define OPC_LD_IN_LEN 4'h4
`define OPC_LD_OUT_LEN 4'h5
`define OPC_LD_PERIPH_CTL 4'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_PTR 10'h000
`define RST_CTL 12'h000
`define RST_IN_LEN 12'h000
`define RST_OUT_LEN 11'h000

`endif

// ===== dma_unit_pkg.sv
package dma_unit_pkg;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] opcode;
        logic [11:0] param;
    } cmd_word_type;

    typedef struct packed {
        logic [9:0] in_base;
        logic [9:0] in_limit;
        logic [9:0] out_base;
        logic [9:0] out_limit;
    } buf_window_type;

    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_CORE_WAIT
    } arb_state_type;
endpackage

// ===== shared_io_ram.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// shared io ram bank, two ports, registered read
// ----------------------------------------
module shared_io_ram #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_a_we,
    input wire logic [ADDR_W-1:0] i_a_addr,
    input wire logic [DATA_W-1:0] i_a_wdata,
    output logic [DATA_W-1:0] o_a_rdata,
    input wire logic i_b_we,
    input wire logic [ADDR_W-1:0] i_b_addr,
    input wire logic [DATA_W-1:0] i_b_wdata,
    output logic [DATA_W-1:0] o_b_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // port a is the dma side, port b the core; one process so the array has one writer
    // on a same-address write the core, served second, lands last
    always_ff @(posedge i_mclk) begin
        if (i_a_we) begin
            mem[i_a_addr] <= i_a_wdata;
        end
        if (i_b_we) begin
            mem[i_b_addr] <= i_b_wdata;
        end
        o_a_rdata <= mem[i_a_addr];
        o_b_rdata <= mem[i_b_addr];
    end
endmodule // shared_io_ram

`default_nettype wire

// ===== modular_dma_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "dma_unit_cfg.svh"

// Function
// - a command word carries the opcode in bits 15 to 12 and the parameter in bits 11 to 0.
// - the command register is write-only and each write executes at once.
// - control, base, limit and length registers load only through commands.
// - the input pointer holds a 10-bit ram address, upper bits reserved, and steps per sample in.
// - the output pointer holds a 10-bit ram address and steps per sample out.
// - each sample takes one right-justified 16-bit ram word.
// - 8-bit samples are written to and read from the low byte.
// - widths are control 12, bases and limits 10, input length 12, output length 11.
// - the input length counter is signed two's complement.
// - opcode 0 loads the input base and opcode 1 the input limit from the low 10 bits.
// - opcode 2 loads the output base and opcode 3 the output limit.
// - one unit serves one peripheral and one 1 Kword bank holding both buffers.
// - on a same-cycle clash the unit goes first and the core waits one cycle.
module modular_dma_unit #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // software register port
    input wire logic i_cmd_we,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic i_iwp_we,
    input wire logic i_orp_we,
    input wire logic [15:0] i_ptr_wdata,
    output logic [15:0] o_iwp_rdata,
    output logic [15:0] o_orp_rdata,
    // peripheral side
    input wire logic i_sample_wide,
    input wire logic i_in_valid,
    input wire logic [DATA_W-1:0] i_in_data,
    input wire logic i_out_req,
    output logic o_out_valid,
    output logic [DATA_W-1:0] o_out_data,
    output logic [11:0] o_periph_ctl,
    output logic signed [11:0] o_in_len,
    output logic [10:0] o_out_len,
    // core side of the shared ram
    input wire logic i_core_req,
    input wire logic i_core_we,
    input wire logic [ADDR_W-1:0] i_core_addr,
    input wire logic [DATA_W-1:0] i_core_wdata,
    output logic o_core_wait,
    output logic o_core_ack,
    output logic [DATA_W-1:0] o_core_rdata
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // the wrap function and the command fields are cut for these widths only
    if (ADDR_W != 10 || DATA_W != 16) begin : g_width_check
        $error("pointer and word widths are fixed at 10 and 16");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    dma_unit_pkg::cmd_word_type cmd;
    dma_unit_pkg::buf_window_type win_q;
    dma_unit_pkg::arb_state_type arb_q;
    logic [ADDR_W-1:0] iwp_q;
    logic [ADDR_W-1:0] orp_q;
    logic [11:0] ctl_q;
    logic signed [11:0] in_len_q;
    logic [10:0] out_len_q;
    logic dma_act;
    logic dma_we;
    logic [ADDR_W-1:0] dma_addr;
    logic [DATA_W-1:0] dma_wdata;
    logic [DATA_W-1:0] ram_a_rdata;
    logic [DATA_W-1:0] ram_b_rdata;
    logic core_go;
    logic core_rd_q;
    logic out_pend_q;
    logic wide_q;

    assign cmd = dma_unit_pkg::cmd_word_type'(i_cmd_wdata);

    // next pointer with circular wrap
    function automatic logic [9:0] step_ptr(input logic [9:0] p,
                                            input logic [9:0] lim,
                                            input logic [9:0] base);
        step_ptr = (p == lim) ? base : 10'(p + 10'h001);
    endfunction

    // right-justify a sample, keeping only the low byte when narrow
    function automatic logic [15:0] justify(input logic [15:0] d, input logic wide);
        justify = wide ? d : {8'h00, d[7:0]};
    endfunction

    // ----------------------------------------
    // command execution
    // ----------------------------------------
    // registers below have no direct software path; commands only
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            win_q <= '0;
            ctl_q <= `RST_CTL;
            in_len_q <= `RST_IN_LEN;
            out_len_q <= `RST_OUT_LEN;
        end else if (i_cmd_we) begin
            case (cmd.opcode)
                `OPC_LD_IN_BASE: win_q.in_base <= cmd.param[`PTR_HI:0];
                `OPC_LD_IN_LIMIT: win_q.in_limit <= cmd.param[`PTR_HI:0];
                `OPC_LD_OUT_BASE: win_q.out_base <= cmd.param[`PTR_HI:0];
                `OPC_LD_OUT_LIMIT: win_q.out_limit <= cmd.param[`PTR_HI:0];
                `OPC_LD_IN_LEN: in_len_q <= signed'(cmd.param);
                `OPC_LD_OUT_LEN: out_len_q <= cmd.param[10:0];
                `OPC_LD_PERIPH_CTL: ctl_q <= cmd.param;
                default: ;
            endcase
        end else if (i_in_valid && in_len_q != 12'sh000) begin
            // signed count down; negative values keep counting
            in_len_q <= in_len_q - 12'sh001;
        end
    end

    // ----------------------------------------
    // pointers
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            iwp_q <= `RST_PTR;
        end else if (i_iwp_we) begin
            iwp_q <= i_ptr_wdata[`PTR_HI:0];
        end else if (i_in_valid) begin
            iwp_q <= step_ptr(iwp_q, win_q.in_limit, win_q.in_base);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            orp_q <= `RST_PTR;
        end else if (i_orp_we) begin
            orp_q <= i_ptr_wdata[`PTR_HI:0];
        end else if (i_out_req && !i_in_valid) begin
            orp_q <= step_ptr(orp_q, win_q.out_limit, win_q.out_base);
        end
    end

    // reserved upper bits read zero
    assign o_iwp_rdata = {6'h00, iwp_q};
    assign o_orp_rdata = {6'h00, orp_q};

    // ----------------------------------------
    // dma port of the ram
    // ----------------------------------------
    // input wins over output if both arrive; peripheral retries output
    assign dma_we = i_in_valid;
    assign dma_act = i_in_valid || i_out_req;
    assign dma_addr = i_in_valid ? iwp_q : orp_q;
    assign dma_wdata = justify(i_in_data, i_sample_wide);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            out_pend_q <= 1'b0;
            wide_q <= 1'b0;
        end else begin
            out_pend_q <= i_out_req && !i_in_valid;
            wide_q <= i_sample_wide;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_out_valid <= 1'b0;
            o_out_data <= 16'h0000;
        end else begin
            o_out_valid <= out_pend_q;
            if (out_pend_q) begin
                o_out_data <= justify(ram_a_rdata, wide_q);
            end
        end
    end

    // ----------------------------------------
    // core arbitration
    // ----------------------------------------
    // a clash holds the core one cycle, then it goes unconditionally
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            arb_q <= dma_unit_pkg::ARB_IDLE;
        end else begin
            case (arb_q)
                dma_unit_pkg::ARB_IDLE:
                    if (i_core_req && dma_act) begin
                        arb_q <= dma_unit_pkg::ARB_CORE_WAIT;
                    end
                dma_unit_pkg::ARB_CORE_WAIT: arb_q <= dma_unit_pkg::ARB_IDLE;
                default: arb_q <= dma_unit_pkg::ARB_IDLE;
            endcase
        end
    end

    // in the wait cycle the core uses port b even if dma is active
    assign core_go = i_core_req &&
        (arb_q == dma_unit_pkg::ARB_CORE_WAIT || !dma_act);
    assign o_core_wait = i_core_req && !core_go;
    assign o_core_ack = core_go;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            core_rd_q <= 1'b0;
            o_core_rdata <= 16'h0000;
        end else begin
            core_rd_q <= core_go && !i_core_we;
            if (core_rd_q) begin
                o_core_rdata <= ram_b_rdata;
            end
        end
    end

    shared_io_ram #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_ram (
        .i_mclk(i_mclk),
        .i_a_we(dma_we),
        .i_a_addr(dma_addr),
        .i_a_wdata(dma_wdata),
        .o_a_rdata(ram_a_rdata),
        .i_b_we(core_go && i_core_we),
        .i_b_addr(i_core_addr),
        .i_b_wdata(i_core_wdata),
        .o_b_rdata(ram_b_rdata)
    );

    assign o_periph_ctl = ctl_q;
    assign o_in_len = in_len_q;
    assign o_out_len = out_len_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_clash;
        i_core_req && dma_act && arb_q == dma_unit_pkg::ARB_IDLE;
    endsequence

    property p_clash_wait;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_clash |-> o_core_wait ##1 (o_core_ack || !i_core_req);
    endproperty
    a_clash_wait: assert property (p_clash_wait)
        else $error("core not served after one wait");

    property p_core_direct;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_core_req && !dma_act) |-> (o_core_ack && !o_core_wait);
    endproperty
    a_core_direct: assert property (p_core_direct) else $error("core stalled needlessly");

    property p_in_base;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_cmd_we && i_cmd_wdata[15:12] == 4'h0) |=> win_q.in_base == $past(i_cmd_wdata[9:0]);
    endproperty
    a_in_base: assert property (p_in_base) else $error("input base not loaded");

    property p_in_limit;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_cmd_we && i_cmd_wdata[15:12] == 4'h1) |=> win_q.in_limit == $past(i_cmd_wdata[9:0]);
    endproperty
    a_in_limit: assert property (p_in_limit) else $error("input limit not loaded");

    property p_out_base;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_cmd_we && i_cmd_wdata[15:12] == 4'h2) |=> win_q.out_base == $past(i_cmd_wdata[9:0]);
    endproperty
    a_out_base: assert property (p_out_base) else $error("output base not loaded");

    property p_out_limit;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_cmd_we && i_cmd_wdata[15:12] == 4'h3) |=> win_q.out_limit == $past(i_cmd_wdata[9:0]);
    endproperty
    a_out_limit: assert property (p_out_limit) else $error("output limit not loaded");

    property p_out_len_load;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_cmd_we && i_cmd_wdata[15:12] == 4'h5) |=> out_len_q == $past(i_cmd_wdata[10:0]);
    endproperty
    a_out_len_load: assert property (p_out_len_load) else $error("output length lost");

    // opcodes above seven decode to nothing and must leave state alone
    property p_unknown_opc;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_cmd_we && i_cmd_wdata[15:12] > 4'h7)
            |=> ($stable(win_q) && $stable(in_len_q) && $stable(out_len_q) && $stable(ctl_q));
    endproperty
    a_unknown_opc: assert property (p_unknown_opc) else $error("stray opcode acted");

    property p_iwp_step;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_in_valid && !i_iwp_we && iwp_q != win_q.in_limit) |=> iwp_q == $past(iwp_q) + 10'h001;
    endproperty
    a_iwp_step: assert property (p_iwp_step) else $error("input pointer did not step");

    property p_wrap;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_in_valid && !i_iwp_we && !i_cmd_we && iwp_q == win_q.in_limit)
            |=> iwp_q == win_q.in_base;
    endproperty
    a_wrap: assert property (p_wrap) else $error("input pointer did not wrap");

    property p_iwp_load;
        @(posedge i_mclk) disable iff (!i_rst_n)
        i_iwp_we |=> iwp_q == $past(i_ptr_wdata[9:0]);
    endproperty
    a_iwp_load: assert property (p_iwp_load) else $error("input pointer not written");

    property p_orp_step;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_out_req && !i_in_valid && !i_orp_we && orp_q != win_q.out_limit)
            |=> orp_q == $past(orp_q) + 10'h001;
    endproperty
    a_orp_step: assert property (p_orp_step) else $error("output pointer did not step");

    property p_orp_wrap;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_out_req && !i_in_valid && !i_orp_we && !i_cmd_we && orp_q == win_q.out_limit)
            |=> orp_q == win_q.out_base;
    endproperty
    a_orp_wrap: assert property (p_orp_wrap) else $error("output pointer did not wrap");

    property p_narrow;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_in_valid && !i_sample_wide) |-> dma_wdata[15:8] == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow sample not right-justified");

    property p_out_narrow;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_out_req && !i_in_valid && !i_sample_wide) |-> ##2 (o_out_data[15:8] == 8'h00);
    endproperty
    a_out_narrow: assert property (p_out_narrow) else $error("narrow output unmasked");

    property p_out_lat;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (i_out_req && !i_in_valid) |-> ##2 o_out_valid;
    endproperty
    a_out_lat: assert property (p_out_lat) else $error("output sample late");

    property p_ctl_only_cmd;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !(i_cmd_we && i_cmd_wdata[15:12] == 4'h7) |=> $stable(ctl_q);
    endproperty
    a_ctl_only_cmd: assert property (p_ctl_only_cmd)
        else $error("control changed without command");

    property p_len_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_cmd_we && in_len_q == 12'sh000) |=> in_len_q == 12'sh000;
    endproperty
    a_len_hold: assert property (p_len_hold) else $error("empty input length moved");

    property p_len_signed;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (!i_cmd_we && i_in_valid && in_len_q != 12'sh000)
            |=> in_len_q == $past(in_len_q) - 12'sh001;
    endproperty
    a_len_signed: assert property (p_len_signed) else $error("input length miscounted");
endmodule // modular_dma_unit

`default_nettype wire

// ===== periph_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// attached peripheral stand-in
// ----------------------------------------
module periph_model (
    input wire logic i_mclk,
    input wire logic i_out_valid,
    input wire logic [15:0] i_out_data,
    output logic o_in_valid,
    output logic [15:0] o_in_data,
    output logic o_out_req,
    output logic o_wide
);
    // idle state; data line carries junk, not zero
    initial begin
        o_in_valid = 1'b0;
        o_in_data = 16'h5A5A;
        o_out_req = 1'b0;
        o_wide = 1'b0;
    end

    // one sample in; line inverted once released so stale data cannot match
    task automatic send(input logic [15:0] d, input logic w);
        @(negedge i_mclk);
        o_wide = w;
        o_in_valid = 1'b1;
        o_in_data = d;
        @(negedge i_mclk);
        o_in_valid = 1'b0;
        o_in_data = ~d;
    endtask

    // one sample out, bounded wait for the valid pulse
    task automatic fetch(input logic w, output logic [15:0] d, output logic ok);
        int n;
        ok = 1'b0;
        d = 16'h0000;
        @(negedge i_mclk);
        o_wide = w;
        o_out_req = 1'b1;
        @(negedge i_mclk);
        o_out_req = 1'b0;
        for (n = 0; n < 6 && !ok; n++) begin
            if (i_out_valid === 1'b1) begin
                ok = 1'b1;
                d = i_out_data;
            end else begin
                @(negedge i_mclk);
            end
        end
    endtask
endmodule // periph_model

`default_nettype wire

// ===== modular_io_dma_command_unit_tb.sv
`timescale 1ns/100ps
`default_nettype none

module modular_io_dma_command_unit_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_we = 1'b0, iwp_we = 1'b0, orp_we = 1'b0;
    logic [15:0] cmd_wdata = 16'h0000, ptr_wdata = 16'h0000;
    logic core_req = 1'b0, core_we = 1'b0;
    logic [9:0] core_addr = 10'h000;
    logic [15:0] core_wdata = 16'h0000;
    logic in_valid, out_req, wide, out_valid, core_wait, core_ack;
    logic [15:0] in_data, out_data, iwp_rd, orp_rd, core_rd;
    logic [11:0] periph_ctl;
    logic signed [11:0] in_len;
    logic [10:0] out_len;
    // ----------------------------------------
    // reference model state
    // ----------------------------------------
    logic [15:0] m_ram [1024];
    logic [9:0] m_iwp = 10'h000, m_orp = 10'h000, ib, il, ob, ol;
    logic [11:0] m_len = 12'h000, m_ctl = 12'h000;
    logic [10:0] m_output_buffer_length = 11'h000;
    int seed = 32'h0E567F5C;
    int n_mismatch = 0, comparisons = 0, cyc = 0;

    initial forever #4 mclk = ~mclk;

    modular_dma_unit i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_cmd_we(cmd_we),
        .i_cmd_wdata(cmd_wdata), .i_iwp_we(iwp_we), .i_orp_we(orp_we),
        .i_ptr_wdata(ptr_wdata), .o_iwp_rdata(iwp_rd), .o_orp_rdata(orp_rd),
        .i_sample_wide(wide), .i_in_valid(in_valid), .i_in_data(in_data),
        .i_out_req(out_req), .o_out_valid(out_valid), .o_out_data(out_data),
        .o_periph_ctl(periph_ctl), .o_in_len(in_len), .o_out_len(out_len),
        .i_core_req(core_req), .i_core_we(core_we), .i_core_addr(core_addr),
        .i_core_wdata(core_wdata), .o_core_wait(core_wait), .o_core_ack(core_ack),
        .o_core_rdata(core_rd));

    periph_model i_per (.i_mclk(mclk), .i_out_valid(out_valid), .i_out_data(out_data),
        .o_in_valid(in_valid), .o_in_data(in_data), .o_out_req(out_req), .o_wide(wide));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmd(input logic [3:0] op, input logic [11:0] p);
        @(negedge mclk);
        cmd_we = 1'b1;
        cmd_wdata = {op, p};
        @(negedge mclk);
        cmd_we = 1'b0;
    endtask

    task automatic ptr_wr(input logic sel, input logic [15:0] v);
        @(negedge mclk);
        iwp_we = !sel;
        orp_we = sel;
        ptr_wdata = v;
        @(negedge mclk);
        iwp_we = 1'b0;
        orp_we = 1'b0;
    endtask

    // core access held until ack; read data sampled once settled
    task automatic core_acc(input logic we, input logic [9:0] a, input logic [15:0] wd,
        output logic [15:0] rd, output logic wt);
        int n;
        wt = 1'b0;
        @(negedge mclk);
        {core_req, core_we, core_addr, core_wdata} = {1'b1, we, a, wd};
        #1;
        for (n = 0; n < 8 && core_ack !== 1'b1; n++) begin
            if (core_wait === 1'b1) wt = 1'b1;
            @(negedge mclk);
            #1;
        end
        check("core_ack", {15'h0000, core_ack}, 16'h0001);
        @(negedge mclk);
        core_req = 1'b0;
        core_we = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rd = core_rd;
    endtask

    task automatic push(input logic [15:0] d, input logic w);
        i_per.send(d, w);
        m_ram[m_iwp] = w ? d : {8'h00, d[7:0]};
        m_iwp = (m_iwp == il) ? ib : m_iwp + 10'h001;
        if (m_len != 12'h000) m_len = m_len - 12'h001;
        check("iwp", iwp_rd, {6'h00, m_iwp});
        check("in_len", {4'h0, in_len}, {4'h0, m_len});
    endtask

    task automatic pull(input logic w);
        logic [15:0] d;
        logic ok;
        i_per.fetch(w, d, ok);
        check("out_ok", {15'h0000, ok}, 16'h0001);
        check("out_data", d, w ? m_ram[m_orp] : {8'h00, m_ram[m_orp][7:0]});
        m_orp = (m_orp == ol) ? ob : m_orp + 10'h001;
        check("orp", orp_rd, {6'h00, m_orp});
    endtask

    // hang guard, well above the hundred or so cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] rd, d;
        logic wt;
        logic [11:0] p;
        logic [9:0] a;
        int i;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        check("ctl_rst", {4'h0, periph_ctl}, 16'h0000);
        check("iwp_rst", iwp_rd, 16'h0000);
        // every opcode once; unknown ones must leave state alone
        for (i = 0; i < 16; i++) begin
            p = 12'($random(seed));
            cmd(i[3:0], p);
            if (i == 4) m_len = p;
            if (i == 5) m_output_buffer_length = p[10:0];
            if (i == 7) m_ctl = p;
            check("ctl", {4'h0, periph_ctl}, {4'h0, m_ctl});
            check("in_len", {4'h0, in_len}, {4'h0, m_len});
            check("out_len", {5'h00, out_len}, {5'h00, m_output_buffer_length});
        end
        // upper parameter bits set on purpose; only the low ten count
        cmd(4'h0, 12'h900);
        cmd(4'h1, 12'h502);
        cmd(4'h2, 12'hA00);
        cmd(4'h3, 12'hE01);
        {ib, il, ob, ol} = {10'h100, 10'h102, 10'h200, 10'h201};
        ptr_wr(1'b0, 16'hFFFF);
        check("iwp_rsv", iwp_rd, 16'h03FF);
        ptr_wr(1'b0, 16'h0100);
        ptr_wr(1'b1, 16'h0200);
        {m_iwp, m_orp} = {10'h100, 10'h200};
        check("orp_wr", orp_rd, 16'h0200);
        cmd(4'h4, 12'h002);
        m_len = 12'h002;
        // five samples through a three-word ring, length runs out
        for (i = 0; i < 5; i++) push(16'($random(seed)), i[0]);
        for (i = 0; i < 3; i++) begin
            core_acc(1'b0, 10'h100 + i[9:0], 16'h0000, rd, wt);
            check("ram_in", rd, m_ram[10'h100 + i[9:0]]);
            check("no_wait", {15'h0000, wt}, 16'h0000);
        end
        for (i = 0; i < 2; i++) begin
            d = 16'($random(seed));
            core_acc(1'b1, 10'h200 + i[9:0], d, rd, wt);
            m_ram[10'h200 + i[9:0]] = d;
        end
        for (i = 0; i < 3; i++) pull(i[0]);
        // minus one counts further down, not up
        cmd(4'h4, 12'hFFF);
        m_len = 12'hFFF;
        push(16'($random(seed)), 1'b1);
        // clash: unit writes first, core waits and sees the new word
        a = m_iwp;
        d = 16'($random(seed));
        fork
            push(d, 1'b1);
            core_acc(1'b0, a, 16'h0000, rd, wt);
        join
        check("clash_wait", {15'h0000, wt}, 16'h0001);
        check("clash_rd", rd, d);
        test_done();
    end
endmodule // modular_io_dma_command_unit_tb

`default_nettype wire
